// *** src/qfr_pkg.sv ***
package qfr_pkg;

   // Opcodes taken in four-line instruction mode.
   localparam logic [7:0] QFR_OP_READ      = 8'heb;
   localparam logic [7:0] QFR_OP_READ_LONG = 8'hec;

   // Upper mode nibble that holds the device in continuous read mode.
   localparam logic [3:0] QFR_CONT_CODE = 4'ha;

   // Phase lengths in serial clocks, one nibble per clock.
   localparam logic [3:0] QFR_OPC_NIBS   = 4'h2;
   localparam logic [3:0] QFR_ADDR3_NIBS = 4'h6;
   localparam logic [3:0] QFR_ADDR4_NIBS = 4'h8;
   localparam logic [3:0] QFR_MODE_NIBS  = 4'h2;
   localparam logic [3:0] QFR_DUMMY_RST  = 4'h6;

   // Register byte offsets.
   localparam logic [7:0] QFR_REG_CTRL   = 8'h00;
   localparam logic [7:0] QFR_REG_STATUS = 8'h04;
   localparam logic [7:0] QFR_REG_ADDR   = 8'h08;
   localparam logic [7:0] QFR_REG_MIDX   = 8'h0c;
   localparam logic [7:0] QFR_REG_MDATA  = 8'h10;

   // Control register fields and reset values.
   localparam int         QFR_CTRL_QPI   = 0;
   localparam int         QFR_CTRL_EXT   = 1;
   localparam int         QFR_CTRL_BUSY  = 2;
   localparam int         QFR_CTRL_DUMMY = 4;
   localparam logic       QFR_QPI_RST    = 1'h1;

   // Status register fields.
   localparam int         QFR_STAT_CONT  = 0;
   localparam int         QFR_STAT_ACT   = 1;
   localparam int         QFR_STAT_IGN   = 2;

   // AXI responses.
   localparam logic [1:0] QFR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] QFR_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      QFR_ST_IDLE   = 3'b000,
      QFR_ST_CMD    = 3'b001,
      QFR_ST_ADDR   = 3'b010,
      QFR_ST_MODE   = 3'b011,
      QFR_ST_DUMMY  = 3'b100,
      QFR_ST_DATA   = 3'b101,
      QFR_ST_IGNORE = 3'b110
   } qfr_state_e;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } qfr_axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } qfr_axil_rsp_s;

endpackage : qfr_pkg

// *** src/qfr_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module qfr_pin_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // Two stages; the first is read only by the second to keep metastability out.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : qfr_pin_sync

`default_nettype wire

// *** src/qfr_quad_read.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module qfr_quad_read #(
   parameter int MEM_AW = 6
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire qfr_pkg::qfr_axil_req_s axil_req,
   output var  qfr_pkg::qfr_axil_rsp_s axil_rsp,
   input  wire logic                  sck,
   input  wire logic                  cs_n,
   input  wire logic [3:0]            io_in,
   output var  logic [3:0]            io_out,
   output var  logic                  io_oe,
   output var  logic                  continuous_read_mode
);
   import qfr_pkg::*;

   localparam int MEM_DEPTH = 1 << MEM_AW;

   // Synchronised pins and the previous serial clock level for edge finding.
   logic [5:0]  pins_s;
   logic        sck_p_q;
   logic        sck_s;
   logic        cs_n_s;
   logic [3:0]  io_s;
   logic        sck_rise;
   logic        sck_fall;

   qfr_pin_sync #(
      .W       (6),
      .RST_VAL (6'h20)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({cs_n, sck, io_in}),
      .q     (pins_s)
   );

   assign cs_n_s   = pins_s[5];
   assign sck_s    = pins_s[4];
   assign io_s     = pins_s[3:0];
   assign sck_rise = sck_s & ~sck_p_q;
   assign sck_fall = ~sck_s & sck_p_q;

   // Previous serial clock level.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_p_q <= 1'h0;
      end else begin
         sck_p_q <= sck_s;
      end
   end

   // Software controls and block state.
   logic                qpi_q;
   logic                ext_q;
   logic                busy_q;
   logic [3:0]          dummy_q;
   logic [MEM_AW-1:0]   midx_q;
   logic [7:0]          mem [MEM_DEPTH];
   qfr_state_e          state_q;
   logic [3:0]          cnt_q;
   logic [7:0]          op_q;
   logic                op_long_q;
   logic [31:0]         addr_q;
   logic                cont_q;
   logic                ign_q;
   logic                nib_hi_q;
   logic                long_now;
   logic [7:0]          rd_byte;
   logic [3:0]          addr_nibs;
   logic [7:0]          opcode;

   assign long_now  = op_long_q | ext_q;
   assign addr_nibs = long_now ? QFR_ADDR4_NIBS : QFR_ADDR3_NIBS;
   assign opcode    = {op_q[3:0], io_s};
   assign rd_byte   = mem[addr_q[MEM_AW-1:0]];

   // Frame sequencer; select high always returns it to idle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= QFR_ST_IDLE;
         cnt_q     <= 4'h0;
         op_q      <= 8'h00;
         op_long_q <= 1'h0;
      end else if (cs_n_s) begin
         state_q <= QFR_ST_IDLE;
      end else begin
         unique case (state_q)
            QFR_ST_IDLE: begin
               if (busy_q || !qpi_q) begin
                  state_q <= QFR_ST_IGNORE;
               end else if (cont_q) begin
                  state_q <= QFR_ST_ADDR;
                  cnt_q   <= addr_nibs;
               end else begin
                  state_q <= QFR_ST_CMD;
                  cnt_q   <= QFR_OPC_NIBS;
               end
            end
            QFR_ST_CMD: begin
               if (sck_rise) begin
                  op_q  <= opcode;
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1) begin
                     if (opcode == QFR_OP_READ_LONG) begin
                        op_long_q <= 1'h1;
                        state_q   <= QFR_ST_ADDR;
                        cnt_q     <= QFR_ADDR4_NIBS;
                     end else if (opcode == QFR_OP_READ) begin
                        op_long_q <= 1'h0;
                        state_q   <= QFR_ST_ADDR;
                        cnt_q     <= ext_q ? QFR_ADDR4_NIBS : QFR_ADDR3_NIBS;
                     end else begin
                        state_q <= QFR_ST_IGNORE;
                     end
                  end
               end
            end
            QFR_ST_ADDR: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1) begin
                     state_q <= QFR_ST_MODE;
                     cnt_q   <= QFR_MODE_NIBS;
                  end
               end
            end
            QFR_ST_MODE: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1) begin
                     // Mode clocks count toward the dummy setting.
                     if (dummy_q <= QFR_MODE_NIBS) begin
                        state_q <= QFR_ST_DATA;
                     end else begin
                        state_q <= QFR_ST_DUMMY;
                        cnt_q   <= dummy_q - QFR_MODE_NIBS;
                     end
                  end
               end
            end
            QFR_ST_DUMMY: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1) begin
                     state_q <= QFR_ST_DATA;
                  end
               end
            end
            QFR_ST_DATA: begin
               state_q <= QFR_ST_DATA;
            end
            QFR_ST_IGNORE: begin
               state_q <= QFR_ST_IGNORE;
            end
            default: begin
               state_q <= QFR_ST_IGNORE;
            end
         endcase
      end
   end

   // Address shifts in a nibble per clock, then counts up per byte sent.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= 32'h0;
      end else if (state_q == QFR_ST_IDLE && !cs_n_s) begin
         addr_q <= 32'h0;
      end else if (state_q == QFR_ST_ADDR && sck_rise) begin
         addr_q <= {addr_q[27:0], io_s};
      end else if (state_q == QFR_ST_DATA && sck_fall && !nib_hi_q) begin
         addr_q <= addr_q + 32'h1;
      end
   end

   // Continuous read flag follows the upper mode nibble only.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cont_q <= 1'h0;
      end else if (state_q == QFR_ST_MODE && sck_rise && cnt_q == QFR_MODE_NIBS) begin
         cont_q <= (io_s == QFR_CONT_CODE);
      end
   end

   // Last-frame-ignored flag for software.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ign_q <= 1'h0;
      end else if (state_q == QFR_ST_IDLE && !cs_n_s) begin
         ign_q <= busy_q | ~qpi_q;
      end else if (state_q == QFR_ST_CMD && sck_rise && cnt_q == 4'h1) begin
         ign_q <= (opcode != QFR_OP_READ) && (opcode != QFR_OP_READ_LONG);
      end
   end

   // Drive data on falling serial clock, high nibble first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_out   <= 4'h0;
         io_oe    <= 1'h0;
         nib_hi_q <= 1'h1;
      end else if (state_q != QFR_ST_DATA) begin
         io_oe    <= 1'h0;
         nib_hi_q <= 1'h1;
      end else if (sck_fall) begin
         io_out   <= nib_hi_q ? rd_byte[7:4] : rd_byte[3:0];
         io_oe    <= 1'h1;
         nib_hi_q <= ~nib_hi_q;
      end
   end

   assign continuous_read_mode = cont_q;

   // Register bus slave: address and data are taken independently.
   logic        aw_have_q;
   logic        w_have_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_fire;
   logic [31:0] rd_val;
   logic        rd_err;
   qfr_axil_rsp_s rsp_q;

   assign wr_fire  = aw_have_q & w_have_q & ~rsp_q.bvalid;
   assign axil_rsp = rsp_q;

   // Read decode; unmapped offsets answer with an error and zero data.
   always_comb begin
      rd_val = 32'h0;
      rd_err = 1'h0;
      unique case (axil_req.araddr[7:0])
         QFR_REG_CTRL: begin
            rd_val[QFR_CTRL_QPI]  = qpi_q;
            rd_val[QFR_CTRL_EXT]  = ext_q;
            rd_val[QFR_CTRL_BUSY] = busy_q;
            rd_val[QFR_CTRL_DUMMY +: 4] = dummy_q;
         end
         QFR_REG_STATUS: begin
            rd_val[QFR_STAT_CONT] = cont_q;
            rd_val[QFR_STAT_ACT]  = ~cs_n_s;
            rd_val[QFR_STAT_IGN]  = ign_q;
         end
         QFR_REG_ADDR:  rd_val = addr_q;
         QFR_REG_MIDX:  rd_val[MEM_AW-1:0] = midx_q;
         QFR_REG_MDATA: rd_val[7:0] = mem[midx_q];
         default:       rd_err = 1'h1;
      endcase
   end

   // Write and read channel handshakes plus register updates.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q     <= '0;
         aw_have_q <= 1'h0;
         w_have_q  <= 1'h0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         qpi_q     <= QFR_QPI_RST;
         ext_q     <= 1'h0;
         busy_q    <= 1'h0;
         dummy_q   <= QFR_DUMMY_RST;
         midx_q    <= '0;
      end else begin
         if (!rsp_q.awready && !aw_have_q && !rsp_q.bvalid) begin
            rsp_q.awready <= 1'h1;
         end
         if (!rsp_q.wready && !w_have_q && !rsp_q.bvalid) begin
            rsp_q.wready <= 1'h1;
         end
         if (axil_req.awvalid && rsp_q.awready) begin
            aw_have_q     <= 1'h1;
            awaddr_q      <= axil_req.awaddr[7:0];
            rsp_q.awready <= 1'h0;
         end
         if (axil_req.wvalid && rsp_q.wready) begin
            w_have_q     <= 1'h1;
            wdata_q      <= axil_req.wdata;
            wstrb_q      <= axil_req.wstrb;
            rsp_q.wready <= 1'h0;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'h0;
            w_have_q     <= 1'h0;
            rsp_q.bvalid <= 1'h1;
            rsp_q.bresp  <= QFR_RESP_OKAY;
            unique case (awaddr_q)
               QFR_REG_CTRL: begin
                  // Instruction mode only moves by software.
                  if (wstrb_q[0]) begin
                     qpi_q   <= wdata_q[QFR_CTRL_QPI];
                     ext_q   <= wdata_q[QFR_CTRL_EXT];
                     busy_q  <= wdata_q[QFR_CTRL_BUSY];
                     dummy_q <= wdata_q[QFR_CTRL_DUMMY +: 4];
                  end
               end
               QFR_REG_MIDX: begin
                  if (wstrb_q[0]) begin
                     midx_q <= wdata_q[MEM_AW-1:0];
                  end
               end
               QFR_REG_MDATA: begin
                  if (wstrb_q[0]) begin
                     midx_q <= midx_q + MEM_AW'(1);
                  end
               end
               QFR_REG_STATUS, QFR_REG_ADDR: begin
                  rsp_q.bresp <= QFR_RESP_OKAY;
               end
               default: rsp_q.bresp <= QFR_RESP_SLVERR;
            endcase
         end
         if (rsp_q.bvalid && axil_req.bready) begin
            rsp_q.bvalid <= 1'h0;
         end
         if (axil_req.arvalid && rsp_q.arready) begin
            rsp_q.arready <= 1'h0;
            rsp_q.rvalid  <= 1'h1;
            rsp_q.rdata   <= rd_val;
            rsp_q.rresp   <= rd_err ? QFR_RESP_SLVERR : QFR_RESP_OKAY;
         end else if (rsp_q.rvalid && axil_req.rready) begin
            rsp_q.rvalid  <= 1'h0;
            rsp_q.arready <= 1'h1;
         end else if (!rsp_q.rvalid) begin
            rsp_q.arready <= 1'h1;
         end
      end
   end

   // Read image; a small array stands in for the flash cells.
   always_ff @(posedge clk) begin
      if (wr_fire && awaddr_q == QFR_REG_MDATA && wstrb_q[0]) begin
         mem[midx_q] <= wdata_q[7:0];
      end
   end

endmodule : qfr_quad_read

`default_nettype wire

// *** sim/qfr_quad_read_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// Watches the register bus and the serial pins of the read block.
module qfr_quad_read_chk (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire qfr_pkg::qfr_axil_req_s axil_req,
   input wire qfr_pkg::qfr_axil_rsp_s axil_rsp,
   input wire logic                   sck,
   input wire logic                   cs_n,
   input wire logic [3:0]             io_in,
   input wire logic [3:0]             io_out,
   input wire logic                   io_oe,
   input wire logic                   continuous_read_mode
);
   import qfr_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Six idle cycles cover the two-flop pin pipeline with margin.
   sequence s_cs_idle;
      cs_n [*6];
   endsequence
   sequence s_sck_high;
      sck [*6];
   endsequence

   // Serial side: drive only inside frames, and never in the opening clocks.
   property p_oe_idle;
      s_cs_idle |-> !io_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("io_oe high while deselected");
   property p_oe_late;
      s_cs_idle ##1 !cs_n |-> !io_oe [*8];
   endproperty
   a_oe_late: assert property (p_oe_late)
      else $error("io_oe high during command phase");
   property p_out_hold;
      s_sck_high ##0 (io_oe && $past(io_oe)) |-> $stable(io_out);
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("io_out moved while sck high");
   property p_cont_hold;
      s_cs_idle |=> $stable(continuous_read_mode);
   endproperty
   a_cont_hold: assert property (p_cont_hold)
      else $error("continuous mode moved outside a frame");

   // Register bus: answers come promptly and stand until accepted.
   property p_rd_ans;
      axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late");
   property p_r_hold;
      axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_b_hold;
      axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_wr_ans;
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
         |-> ##[1:3] axil_rsp.bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write answer late");
   property p_b_block;
      axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready;
   endproperty
   a_b_block: assert property (p_b_block)
      else $error("new write taken before answer");
endmodule : qfr_quad_read_chk

bind qfr_quad_read qfr_quad_read_chk i_chk (.clk(clk), .rst_n(rst_n), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe), .continuous_read_mode(continuous_read_mode));

`default_nettype wire

// *** sim/qfr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Flash controller on the far side: mode 0, sck idles low between frames.
module qfr_host_model (
   input  wire logic       clk,
   input  wire logic [3:0] line_in,
   input  wire logic       dev_oe,
   output var  logic       sck,
   output var  logic       cs_n,
   output var  logic [3:0] io_drv
);
   logic saw_oe;

   // Idle pins at time zero.
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io_drv = 4'h5;
      saw_oe = 1'b0;
   end

   // One serial clock; released lines flip so a stale value never looks valid.
   task automatic nib(input logic [3:0] n, input logic drv, output logic [3:0] seen);
      io_drv <= drv ? n : ~io_drv;
      repeat (10) @(posedge clk);
      sck <= 1'b1;
      seen = line_in;
      saw_oe = saw_oe | dev_oe;
      repeat (10) @(posedge clk);
      sck <= 1'b0;
   endtask : nib

   // One read frame; the mode nibbles count inside the dummy total.
   task automatic frame(input logic op_en, input logic [7:0] op, input logic [31:0] addr,
                        input int anib, input logic [7:0] mode, input int dummy,
                        output logic [7:0] rd [4]);
      logic [3:0] hi;
      logic [3:0] lo;
      saw_oe = 1'b0;
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      if (op_en) begin
         nib(op[7:4], 1'b1, hi);
         nib(op[3:0], 1'b1, hi);
      end
      for (int i = anib - 1; i >= 0; i--) nib(addr[4*i +: 4], 1'b1, hi);
      nib(mode[7:4], 1'b1, hi);
      nib(mode[3:0], dummy > 2, hi);
      for (int i = 2; i < dummy; i++) nib(4'h0, 1'b0, hi);
      for (int b = 0; b < 4; b++) begin
         nib(4'h0, 1'b0, hi);
         nib(4'h0, 1'b0, lo);
         rd[b] = {hi, lo};
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : frame
endmodule : qfr_host_model

`default_nettype wire

// *** sim/qfr_quad_read_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module qfr_quad_read_tb;
   import qfr_pkg::*;

   logic          clk;
   logic          rst_n;
   qfr_axil_req_s req;
   qfr_axil_rsp_s rsp;
   logic          sck;
   logic          cs_n;
   logic          io_oe;
   logic          cont;
   logic [3:0]    io_in;
   logic [3:0]    io_out;
   logic [3:0]    io_drv;
   logic [7:0]    img [64];
   int            bad_count;
   int            n_compared;
   int            seed;

   qfr_quad_read #(.MEM_AW(6)) i_dut (.clk(clk), .rst_n(rst_n), .axil_req(req),
      .axil_rsp(rsp), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .continuous_read_mode(cont));
   qfr_host_model i_host (.clk(clk), .line_in(io_in), .dev_oe(io_oe), .sck(sck),
      .cs_n(cs_n), .io_drv(io_drv));

   // The device wins the shared lines whenever it enables its drivers.
   assign io_in = io_oe ? io_out : io_drv;

   // System clock, 8 ns period.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // A wait that ran out of its bound ends the run.
   task automatic stall(input int n);
      if (n >= 60) begin
         bad_count++;
         report_and_stop();
      end
   endtask : stall

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      int   n;
      aw = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge clk);
      req.awaddr <= {24'h0, a};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         aw |= req.awvalid & rsp.awready;
         w |= req.wvalid & rsp.wready;
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end while (!(aw && w) && n < 60);
      while (!rsp.bvalid && n < 60) begin
         @(posedge clk);
         n++;
      end
      r = rsp.bresp;
      req.bready <= 1'b0;
      stall(n);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      req.araddr <= {24'h0, a};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (!rsp.arready && n < 60);
      req.arvalid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (!rsp.rvalid && n < 60);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
      stall(n);
   endtask : axi_rd

   function automatic logic [31:0] ctrl_val(input logic ext, input logic busy,
                                            input logic [3:0] dum);
      return {24'h0, dum, 1'b0, busy, ext, QFR_QPI_RST};
   endfunction : ctrl_val

   // One frame, then data against the image copy (or, for an ignored frame, no drive seen) and the mode flag.
   task automatic run(input logic op_en, input logic [7:0] op, input logic [31:0] addr,
                      input int anib, input logic [7:0] mode, input int dummy,
                      input logic cont_exp, input logic ign);
      logic [7:0] rd [4];
      i_host.frame(op_en, op, addr, anib, mode, dummy, rd);
      if (ign) chk("oe", {31'h0, i_host.saw_oe}, 32'h0);
      else for (int k = 0; k < 4; k++) chk("data", {24'h0, rd[k]}, {24'h0, img[6'(addr + k)]});
      chk("cont", {31'h0, cont}, {31'h0, cont_exp});
      $display("frame op %h mode %h finished", op, mode);
   endtask : run

   // Main sequence.
   initial begin
      logic [1:0]  r;
      logic [31:0] d;
      int          dums [3];
      bad_count = 0;
      n_compared = 0;
      seed = 32'h7dac;
      dums = '{6, 2, 9};
      req = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      axi_rd(QFR_REG_CTRL, d, r);
      chk("ctrl", d, ctrl_val(1'b0, 1'b0, QFR_DUMMY_RST));
      axi_rd(8'h40, d, r);
      chk("resp", {30'h0, r}, {30'h0, QFR_RESP_SLVERR});
      axi_wr(8'h40, 32'h0, r);
      chk("bresp", {30'h0, r}, {30'h0, QFR_RESP_SLVERR});
      axi_wr(QFR_REG_MIDX, 32'h0, r);
      chk("bresp", {30'h0, r}, {30'h0, QFR_RESP_OKAY});
      for (int i = 0; i < 64; i++) begin
         img[i] = 8'($random(seed));
         axi_wr(QFR_REG_MDATA, {24'h0, img[i]}, r);
      end
      $display("register checks and image load finished");
      // Three-byte reads across dummy settings, the minimum included.
      for (int i = 0; i < 3; i++) begin
         axi_wr(QFR_REG_CTRL, ctrl_val(1'b0, 1'b0, 4'(dums[i])), r);
         run(1'b1, QFR_OP_READ, 32'($random(seed)) & 32'hffffff, 6,
             {4'h5, 4'($random(seed))}, dums[i], 1'b0, 1'b0);
      end
      // Long opcode enters continuous mode; the next frame skips the opcode and leaves.
      run(1'b1, QFR_OP_READ_LONG, $random(seed), 8, 8'ha5, 9, 1'b1, 1'b0);
      run(1'b0, 8'h0, $random(seed), 8, 8'h3c, 9, 1'b0, 1'b0);
      // Extended addressing with the short opcode; low mode bits do not matter.
      axi_wr(QFR_REG_CTRL, ctrl_val(1'b1, 1'b0, 4'h6), r);
      run(1'b1, QFR_OP_READ, $random(seed), 8, 8'ha0, 6, 1'b1, 1'b0);
      run(1'b0, 8'h0, $random(seed), 8, 8'haf, 6, 1'b1, 1'b0);
      // A busy device ignores the frame and keeps its mode.
      axi_wr(QFR_REG_CTRL, ctrl_val(1'b1, 1'b1, 4'h6), r);
      run(1'b0, 8'h0, $random(seed), 8, 8'h00, 6, 1'b1, 1'b1);
      axi_rd(QFR_REG_STATUS, d, r);
      chk("status", {29'h0, d[2:0]}, 32'h5);
      // Single-line instruction mode: the four-line frame is not taken.
      axi_wr(QFR_REG_CTRL, ctrl_val(1'b1, 1'b0, 4'h6) ^ 32'h1, r);
      run(1'b1, QFR_OP_READ, $random(seed), 8, 8'h00, 6, 1'b1, 1'b1);
      axi_wr(QFR_REG_CTRL, ctrl_val(1'b1, 1'b0, 4'h6), r);
      run(1'b0, 8'h0, $random(seed), 8, 8'h00, 6, 1'b0, 1'b0);
      // Another command's opcode is ignored and cannot enter continuous mode.
      run(1'b1, 8'h6b, $random(seed), 8, 8'ha0, 6, 1'b0, 1'b1);
      run(1'b1, QFR_OP_READ, $random(seed), 8, 8'ha3, 6, 1'b1, 1'b0);
      axi_rd(QFR_REG_CTRL, d, r);
      chk("ctrl", d, ctrl_val(1'b1, 1'b0, 4'h6));
      // A reset in mid-run drops continuous mode and restores the controls.
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("cont", {31'h0, cont}, 32'h0);
      axi_rd(QFR_REG_CTRL, d, r);
      chk("ctrl", d, ctrl_val(1'b0, 1'b0, QFR_DUMMY_RST));
      $display("mode and reset checks finished");
      report_and_stop();
   end
endmodule : qfr_quad_read_tb

`default_nettype wire
